/* File: rtl/artc_pkg.sv */
package artc_pkg;
	// special-function register addresses
	localparam logic [7:0] ADDR_CONTROL     = 8'hC8;
	localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hCA;
	localparam logic [7:0] ADDR_COUNT_LOW   = 8'hCC;
	localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hCD;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCE;
	localparam logic [7:0] ADDR_CLOCK_CTRL  = 8'h8E;

	// control register bit positions
	localparam int BIT_HIGH_FLAG  = 7;
	localparam int BIT_LOW_FLAG   = 6;
	localparam int BIT_LOW_IRQ_EN = 5;
	localparam int BIT_CAPTURE_EN = 4;
	localparam int BIT_SPLIT      = 3;
	localparam int BIT_RUN        = 2;
	localparam int BIT_EXT_CLOCK  = 0;

	// clock control register bit positions
	localparam int BIT_HIGH_CLKSEL = 5;
	localparam int BIT_LOW_CLKSEL  = 4;

	localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFD;
	localparam logic [7:0] RESET_BYTE         = 8'h00;
	localparam logic [7:0] BYTE_MAX           = 8'hFF;
	localparam logic [7:0] BYTE_ONE           = 8'h01;

	// prescaler figures
	localparam int SYS_DIVIDE = 12;
	localparam int EXT_DIVIDE = 8;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} artc_sfr_t;

	typedef struct packed {
		logic high_flag;
		logic low_flag;
		logic low_irq_en;
		logic capture_en;
		logic split;
		logic run;
		logic ext_clock;
	} artc_ctrl_t;
endpackage

/* File: rtl/artc_tick_gen.sv */
`timescale 1ns/1ns
module artc_tick_gen #(
	parameter int SYS_DIV = artc_pkg::SYS_DIVIDE,
	parameter int EXT_DIV = artc_pkg::EXT_DIVIDE
) (
	// clocking
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic clk_en,
	// control
	input  wire logic ext_clock_select,
	input  wire logic ext_osc,
	// tick out
	output logic      tick
);
	typedef struct packed {
		logic [2:0] sync;
		logic [3:0] sys_cnt;
		logic [2:0] ext_cnt;
		logic       tick;
	} artc_tick_state_t;

	localparam logic [3:0] SYS_LAST = 4'(SYS_DIV - 1);
	localparam logic [2:0] EXT_LAST = 3'(EXT_DIV - 1);

	artc_tick_state_t s;
	artc_tick_state_t next_s;
	logic             ext_rise;

	// edge counted when stage two is high and stage three is still low
	assign ext_rise = s.sync[1] & ~s.sync[2];

	always_comb
	begin
		next_s = s;
		next_s.sync = {s.sync[1:0], ext_osc};
		next_s.tick = 1'b0;
		next_s.sys_cnt = (s.sys_cnt == SYS_LAST) ? 4'h0 : s.sys_cnt + 4'h1;
		if (ext_rise)
		begin
			next_s.ext_cnt = s.ext_cnt + 3'h1;
		end
		if (ext_clock_select)
		begin
			next_s.tick = ext_rise && (s.ext_cnt == EXT_LAST);
		end
		else
		begin
			next_s.tick = (s.sys_cnt == SYS_LAST);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
		end
		else if (clk_en)
		begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

	sys_period_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && !ext_clock_select && $past(clk_en) && $past(!ext_clock_select) && tick)
		|-> ##1 !tick)
		else $error("prescaled tick too frequent");
endmodule

/* File: rtl/artc_timer.sv */
`timescale 1ns/1ns
// Overview of operation
// - with the low-byte enable and the timer interrupt enabled, a low-byte overflow raises the interrupt.
// - in split mode the external select bit applies to both bytes together.
// - external select at 0 gives a tick of the system clock divided by 12.
// - external select at 1 gives the synchronized external clock divided by 8.
// - each byte's clock select picks the raw system clock or the external-select tick; the high byte's select only acts in split mode.
// - the low reload register holds the low reload byte used for the low counter byte.
// - the high reload register holds the high reload byte used for the high counter byte.
// - the high flag sets when the high byte steps past 0xFF and reloads from the high reload byte, in 16-bit mode on 0xFFFF.
// - the low flag sets whenever the low byte rolls over, in either mode.
// - flags are cleared only by software writes, never by hardware.
module artc_timer (
	// clocking
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire logic                clk_en,
	// special-function register port
	input  artc_pkg::artc_sfr_t      sfr,
	output logic [7:0]               sfr_rdata,
	// outside
	input  wire logic                ext_osc,
	input  wire logic                timer_irq_enable,
	output logic                     timer_irq
);
	typedef struct packed {
		artc_pkg::artc_ctrl_t ctrl;
		logic [7:0]           reload_low;
		logic [7:0]           reload_high;
		logic [7:0]           count_low;
		logic [7:0]           count_high;
		logic                 high_clksel;
		logic                 low_clksel;
		logic [7:0]           rdata;
		logic                 irq;
	} artc_state_t;

	artc_state_t s;
	artc_state_t next_s;
	logic        sel_tick;
	logic        low_step;
	logic        high_step;
	logic        low_wrap;
	logic        high_wrap;
	logic        set_low;
	logic        set_high;

	artc_tick_gen u_tick (
		.sys_clk         (sys_clk),
		.rst_n           (rst_n),
		.clk_en          (clk_en),
		.ext_clock_select(s.ctrl.ext_clock),
		.ext_osc         (ext_osc),
		.tick            (sel_tick)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	function automatic logic [7:0] ctrl_byte(input artc_pkg::artc_ctrl_t c);
		logic [7:0] v;
		v = artc_pkg::RESET_BYTE;
		v[artc_pkg::BIT_HIGH_FLAG] = c.high_flag;
		v[artc_pkg::BIT_LOW_FLAG] = c.low_flag;
		v[artc_pkg::BIT_LOW_IRQ_EN] = c.low_irq_en;
		v[artc_pkg::BIT_CAPTURE_EN] = c.capture_en;
		v[artc_pkg::BIT_SPLIT] = c.split;
		v[artc_pkg::BIT_RUN] = c.run;
		v[artc_pkg::BIT_EXT_CLOCK] = c.ext_clock;
		return v & artc_pkg::CONTROL_WRITE_MASK;
	endfunction

	always_comb
	begin
		// per-byte choice of raw clock or selected tick
		low_step = s.ctrl.run & (s.low_clksel | sel_tick);
		high_step = s.ctrl.split ? (s.ctrl.run & (s.high_clksel | sel_tick))
			: (low_step & hit(s.count_low, artc_pkg::BYTE_MAX));
		low_wrap = low_step & hit(s.count_low, artc_pkg::BYTE_MAX);
		high_wrap = high_step & hit(s.count_high, artc_pkg::BYTE_MAX);
		set_low = low_wrap;
		set_high = high_wrap;
	end

	always_comb
	begin
		next_s = s;
		next_s.irq = 1'b0;
		// counting
		if (low_wrap)
		begin
			next_s.count_low = s.reload_low;
		end
		else if (low_step)
		begin
			next_s.count_low = s.count_low + artc_pkg::BYTE_ONE;
		end
		if (high_wrap)
		begin
			next_s.count_high = s.reload_high;
		end
		else if (high_step)
		begin
			next_s.count_high = s.count_high + artc_pkg::BYTE_ONE;
		end
		// register writes
		if (sfr.wr)
		begin
			if (sfr.addr == artc_pkg::ADDR_CONTROL)
			begin
				next_s.ctrl.high_flag = sfr.wdata[artc_pkg::BIT_HIGH_FLAG];
				next_s.ctrl.low_flag = sfr.wdata[artc_pkg::BIT_LOW_FLAG];
				next_s.ctrl.low_irq_en = sfr.wdata[artc_pkg::BIT_LOW_IRQ_EN];
				next_s.ctrl.capture_en = sfr.wdata[artc_pkg::BIT_CAPTURE_EN];
				next_s.ctrl.split = sfr.wdata[artc_pkg::BIT_SPLIT];
				next_s.ctrl.run = sfr.wdata[artc_pkg::BIT_RUN];
				next_s.ctrl.ext_clock = sfr.wdata[artc_pkg::BIT_EXT_CLOCK];
			end
			else if (sfr.addr == artc_pkg::ADDR_RELOAD_LOW)
			begin
				next_s.reload_low = sfr.wdata;
			end
			else if (sfr.addr == artc_pkg::ADDR_RELOAD_HIGH)
			begin
				next_s.reload_high = sfr.wdata;
			end
			else if (sfr.addr == artc_pkg::ADDR_COUNT_LOW)
			begin
				next_s.count_low = sfr.wdata;
			end
			else if (sfr.addr == artc_pkg::ADDR_COUNT_HIGH)
			begin
				next_s.count_high = sfr.wdata;
			end
			else if (sfr.addr == artc_pkg::ADDR_CLOCK_CTRL)
			begin
				next_s.high_clksel = sfr.wdata[artc_pkg::BIT_HIGH_CLKSEL];
				next_s.low_clksel = sfr.wdata[artc_pkg::BIT_LOW_CLKSEL];
			end
		end
		// set wins over a clearing write in the same cycle
		if (set_low)
		begin
			next_s.ctrl.low_flag = 1'b1;
		end
		if (set_high)
		begin
			next_s.ctrl.high_flag = 1'b1;
		end
		// read data registered
		if (sfr.rd)
		begin
			if (sfr.addr == artc_pkg::ADDR_CONTROL)
			begin
				next_s.rdata = ctrl_byte(s.ctrl);
			end
			else if (sfr.addr == artc_pkg::ADDR_RELOAD_LOW)
			begin
				next_s.rdata = s.reload_low;
			end
			else if (sfr.addr == artc_pkg::ADDR_RELOAD_HIGH)
			begin
				next_s.rdata = s.reload_high;
			end
			else if (sfr.addr == artc_pkg::ADDR_COUNT_LOW)
			begin
				next_s.rdata = s.count_low;
			end
			else if (sfr.addr == artc_pkg::ADDR_COUNT_HIGH)
			begin
				next_s.rdata = s.count_high;
			end
			else if (sfr.addr == artc_pkg::ADDR_CLOCK_CTRL)
			begin
				next_s.rdata = artc_pkg::RESET_BYTE;
				next_s.rdata[artc_pkg::BIT_HIGH_CLKSEL] = s.high_clksel;
				next_s.rdata[artc_pkg::BIT_LOW_CLKSEL] = s.low_clksel;
			end
			else
			begin
				next_s.rdata = artc_pkg::RESET_BYTE;
			end
		end
		// level interrupt from the flags, low flag only when its enable is set
		next_s.irq = timer_irq_enable & (next_s.ctrl.high_flag
			| (next_s.ctrl.low_irq_en & next_s.ctrl.low_flag));
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
		end
		else if (clk_en)
		begin
			s <= next_s;
		end
	end

	assign sfr_rdata = s.rdata;
	assign timer_irq = s.irq;

	low_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && set_low) |=> s.ctrl.low_flag)
		else $error("low flag not set on low wrap");
	high_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && set_high) |=> s.ctrl.high_flag)
		else $error("high flag not set on high wrap");
	flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && s.ctrl.low_flag && !(sfr.wr && sfr.addr == artc_pkg::ADDR_CONTROL)) |=> s.ctrl.low_flag)
		else $error("low flag cleared by hardware");
	low_reload_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && low_wrap && !sfr.wr) |=> s.count_low == $past(s.reload_low))
		else $error("low byte not reloaded");
	high_reload_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && high_wrap && !sfr.wr) |=> s.count_high == $past(s.reload_high))
		else $error("high byte not reloaded");
	run_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && !s.ctrl.run && !sfr.wr) |=> $stable(s.count_low) && $stable(s.count_high))
		else $error("counter moved while stopped");
	carry_16_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!s.ctrl.split && high_step) |-> low_wrap)
		else $error("high byte stepped without carry");
	unused_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$past(sfr.rd && clk_en) && $past(sfr.addr) == artc_pkg::ADDR_CONTROL
		|-> (sfr_rdata & ~artc_pkg::CONTROL_WRITE_MASK) == artc_pkg::RESET_BYTE)
		else $error("unused control bit read as one");
	irq_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && timer_irq_enable && s.ctrl.low_irq_en && set_low) |=> timer_irq)
		else $error("low overflow interrupt missing");
	fast_clock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s.ctrl.run && s.low_clksel) |-> low_step)
		else $error("raw clock select not stepping");

	wrap16_c: cover property (@(posedge sys_clk) !s.ctrl.split && set_high);
	split_c: cover property (@(posedge sys_clk) s.ctrl.split && set_high && !set_low);
	race_c: cover property (@(posedge sys_clk) set_low && sfr.wr && sfr.addr == artc_pkg::ADDR_CONTROL);
	ext_c: cover property (@(posedge sys_clk) s.ctrl.ext_clock && s.ctrl.run && sel_tick);
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ns
module testbench;
	localparam logic [7:0] A_CTL = artc_pkg::ADDR_CONTROL;
	localparam logic [7:0] A_RLL = artc_pkg::ADDR_RELOAD_LOW;
	localparam logic [7:0] A_RLH = artc_pkg::ADDR_RELOAD_HIGH;
	localparam logic [7:0] A_CL  = artc_pkg::ADDR_COUNT_LOW;
	localparam logic [7:0] A_CH  = artc_pkg::ADDR_COUNT_HIGH;
	localparam logic [7:0] A_CK  = artc_pkg::ADDR_CLOCK_CTRL;
	logic                sys_clk = 1'b0;
	logic                rst_n = 1'b0;
	artc_pkg::artc_sfr_t sfr = '0;
	logic [7:0]          sfr_rdata;
	logic                ext_osc = 1'b0;
	logic                timer_irq_enable = 1'b0;
	logic                timer_irq;
	logic                clk_en = 1'b1;
	logic [1:0]          osc_div = 2'h0;
	logic [7:0]          v;
	int                  mismatches = 0;
	int                  n_checks = 0;

	artc_timer u_dut (
		.sys_clk          (sys_clk),
		.rst_n            (rst_n),
		.clk_en           (clk_en),
		.sfr              (sfr),
		.sfr_rdata        (sfr_rdata),
		.ext_osc          (ext_osc),
		.timer_irq_enable (timer_irq_enable),
		.timer_irq        (timer_irq)
	);

	always #50 sys_clk = ~sys_clk;

	// external oscillator, one rise every six system clocks
	always @(posedge sys_clk)
	begin
		osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
		if (osc_div == 2'h2)
			ext_osc <= ~ext_osc;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		sfr.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		sfr.rd <= 1'b0;
		@(negedge sys_clk);
		d = sfr_rdata;
	endtask

	task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
		rd(a, v);
		check(v, exp);
	endtask

	// range check: prescaler and synchronizer phase blur the exact count
	task automatic expect_rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
		rd(a, v);
		n_checks++;
		// an unknown count must not slip through as a pass
		if ((v >= lo && v <= hi) !== 1'b1)
		begin
			mismatches++;
			$display("mismatch at %0t ns: seen %h expected %h to %h", $time, v, lo, hi);
		end
	endtask

	task automatic wait_irq(input logic level);
		// sampled on the falling edge, clear of the launching edge
		for (int i = 0; i < 20 && timer_irq !== level; i++)
			@(negedge sys_clk);
		check({7'h00, timer_irq}, {7'h00, level});
		if (timer_irq !== level)
			print_verdict();
	endtask

	task automatic load(input logic [7:0] ck, input logic [7:0] cl, input logic [7:0] ch);
		wr(A_CK, ck);
		wr(A_CL, cl);
		wr(A_CH, ch);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		expect_reg(A_CTL, 8'h00);
		expect_reg(A_RLL, 8'h00);
		expect_reg(A_RLH, 8'h00);
		expect_reg(A_CL, 8'h00);
		expect_reg(A_CH, 8'h00);
		expect_reg(A_CK, 8'h00);
		wr(A_CTL, 8'h02);
		expect_reg(A_CTL, 8'h00);
		wr(A_CTL, 8'h3B);
		expect_reg(A_CTL, 8'h39);
		wr(A_CK, 8'hFF);
		expect_reg(A_CK, 8'h30);
		wr(A_RLL, 8'hA5);
		expect_reg(A_RLL, 8'hA5);
		wr(A_RLH, 8'h5A);
		expect_reg(A_RLH, 8'h5A);
		$display("test registers done");

		wr(A_RLL, 8'h34);
		wr(A_RLH, 8'h12);
		load(8'h30, 8'hFE, 8'hFF);
		wr(A_CTL, 8'h04);
		idle(3);
		expect_reg(A_CTL, 8'hC4);
		expect_reg(A_CH, 8'h12);
		expect_rng(A_CL, 8'h34, 8'h50);
		idle(20);
		expect_reg(A_CTL, 8'hC4);
		wr(A_CTL, 8'h00);
		rd(A_CL, v);
		idle(10);
		expect_reg(A_CL, v);
		expect_reg(A_CTL, 8'h00);
		$display("test sixteen bit done");

		wr(A_RLL, 8'hF0);
		wr(A_RLH, 8'h80);
		load(8'h30, 8'hFE, 8'hFE);
		wr(A_CTL, 8'h0C);
		idle(2);
		expect_reg(A_CTL, 8'hCC);
		expect_rng(A_CH, 8'h80, 8'hA0);
		expect_rng(A_CL, 8'hF0, 8'hFF);
		wr(A_CTL, 8'h00);
		$display("test split done");

		wr(A_RLL, 8'h00);
		load(8'h10, 8'hFE, 8'h00);
		@(posedge sys_clk);
		timer_irq_enable <= 1'b1;
		wr(A_CTL, 8'h2C);
		wait_irq(1'b1);
		expect_reg(A_CTL, 8'h6C);
		wr(A_CTL, 8'h4C);
		wait_irq(1'b0);
		idle(36);
		expect_rng(A_CH, 8'h02, 8'h06);
		wr(A_CTL, 8'h00);
		@(posedge sys_clk);
		timer_irq_enable <= 1'b0;
		$display("test interrupt done");

		load(8'h00, 8'h00, 8'h00);
		wr(A_CTL, 8'h0D);
		idle(480);
		wr(A_CTL, 8'h00);
		expect_rng(A_CL, 8'h09, 8'h0B);
		expect_reg(A_CH, v);
		$display("test external clock done");

		load(8'h00, 8'h00, 8'h00);
		wr(A_CTL, 8'h04);
		idle(120);
		wr(A_CTL, 8'h00);
		expect_rng(A_CL, 8'h09, 8'h0B);
		expect_reg(A_CH, 8'h00);
		$display("test prescaler done");

		// raw clock counts each enabled edge; ten frozen edges must not count
		load(8'h30, 8'h00, 8'h00);
		wr(A_CTL, 8'h04);
		clk_en <= 1'b0;
		idle(10);
		clk_en <= 1'b1;
		wr(A_CTL, 8'h00);
		expect_reg(A_CL, 8'h02);
		expect_reg(A_CH, 8'h00);
		$display("test clock enable done");
		print_verdict();
	end

endmodule
